// ===== core/spc_pkg.sv
// Behaviour
// R1: The node address is switches one to six, switch one the least significant bit, on reads as one.
// R2: The rate code is switches seven and eight, switch seven the least significant bit, on reads as one.
// R3: The switch address and rate apply to the RS-485 port only, never to the RS-232 settings; the code applies them to node_addr and rate whatever is_rs485 is.
// R4: A zero address field selects the node address held in non-volatile memory.
// R5: A zero rate code selects the bit rate held in non-volatile memory.
// R6: Rate code one gives 9.6 kbps, two gives 38.4 kbps, three gives 115.2 kbps.
// R7: Encoder A, B and index are driven out as buffered complementary pairs.
// R8: The port runs as RS-485 when the select input is tied to isolated ground, else as RS-232.
// R9: The eight switches are latched once after reset release and held until the next reset.
package spc_pkg;
    localparam int SW_W = 8;
    localparam int ADDR_W = 6;
    localparam int RATE_W = 2;
    localparam int ADDR_LSB = 0;
    localparam int RATE_LSB = 6;
    localparam logic [ADDR_W-1:0] ADDR_RST = 6'h00;
    localparam logic [RATE_W-1:0] CODE_NVM = 2'h0;
    localparam logic [RATE_W-1:0] CODE_9K6 = 2'h1;
    localparam logic [RATE_W-1:0] CODE_38K4 = 2'h2;
    localparam logic [RATE_W-1:0] CODE_115K2 = 2'h3;

    typedef enum logic [1:0] {
        SPC_RATE_9K6 = 2'h0,
        SPC_RATE_38K4 = 2'h1,
        SPC_RATE_115K2 = 2'h2
    } spc_rate_t;

    typedef struct packed {
        logic a;
        logic b;
        logic idx;
    } spc_enc_t;

    typedef struct packed {
        logic is_rs485;
        logic [ADDR_W-1:0] node_addr;
        spc_rate_t rate;
        logic addr_from_nvm;
        logic rate_from_nvm;
    } spc_cfg_t;

    // Nonzero rate code to bit rate
    function automatic spc_rate_t spc_decode_rate(input logic [RATE_W-1:0] code);
        spc_rate_t r;
        r = SPC_RATE_9K6;
        unique case (code)
            CODE_38K4: r = SPC_RATE_38K4;
            CODE_115K2: r = SPC_RATE_115K2;
            default: r = SPC_RATE_9K6;
        endcase
        return r;
    endfunction : spc_decode_rate
endpackage : spc_pkg

// ===== core/spc_sync.sv
`timescale 1ns/1ps
module spc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Data
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : spc_sync

// ===== core/spc_top.sv
`timescale 1ns/1ps
module spc_top (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // Switches and interface select pin
    input wire logic [spc_pkg::SW_W-1:0] i_switch,
    input wire logic i_sel_pin,
    // Non-volatile memory values
    input wire logic [spc_pkg::ADDR_W-1:0] i_nvm_addr,
    input wire spc_pkg::spc_rate_t i_nvm_rate,
    // Encoder channels from feedback input
    input wire spc_pkg::spc_enc_t i_enc,
    // Configuration
    output spc_pkg::spc_cfg_t o_cfg,
    output logic o_cfg_valid,
    // Buffered encoder outputs
    output logic o_buffered_chan_a_pos,
    output logic o_buffered_chan_a_neg,
    output logic o_buffered_chan_b_pos,
    output logic o_buffered_chan_b_neg,
    output logic o_buffered_index_pos,
    output logic o_buffered_index_neg
);
    import spc_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [SW_W-1:0] sw_s;
    logic sel_s;
    logic [2:0] enc_s;

    // Switches, select and encoder share one two-stage synchroniser
    spc_sync #(.W(SW_W + 4)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_switch, i_sel_pin, i_enc}),
        .o_sync({sw_s, sel_s, enc_s})
    );

    // ****************************************
    // Latch sequence
    // ****************************************
    typedef enum logic [1:0] {
        SPC_WAIT = 2'b00,
        SPC_WAIT2 = 2'b01,
        SPC_SAMPLE = 2'b11,
        SPC_HOLD = 2'b10
    } spc_state_t;

    spc_state_t state_q, state_d;
    logic [SW_W-1:0] sw_q, sw_d;

    // Reset clears both synchroniser stages, two waits refill them
    always_comb begin
        state_d = state_q;
        sw_d = sw_q;
        unique case (state_q)
            SPC_WAIT: state_d = SPC_WAIT2;
            SPC_WAIT2: state_d = SPC_SAMPLE;
            SPC_SAMPLE: begin
                sw_d = sw_s; // R9
                state_d = SPC_HOLD;
            end
            SPC_HOLD: state_d = SPC_HOLD; // R9
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= SPC_WAIT;
            sw_q <= '0;
        end else begin
            state_q <= state_d;
            sw_q <= sw_d;
        end
    end

    // ****************************************
    // Configuration decode
    // ****************************************
    logic [ADDR_W-1:0] sw_addr;
    logic [RATE_W-1:0] sw_rate;
    spc_cfg_t cfg_q, cfg_d;
    logic valid_q, valid_d;

    assign sw_addr = sw_q[ADDR_LSB +: ADDR_W]; // R1
    assign sw_rate = sw_q[RATE_LSB +: RATE_W]; // R2

    always_comb begin
        cfg_d = cfg_q;
        valid_d = (state_q == SPC_HOLD);
        cfg_d.is_rs485 = !sel_s; // R8
        if (state_q == SPC_HOLD) begin
            // Switch values steer node_addr and rate in both RS-485 and RS-232 modes
            cfg_d.addr_from_nvm = (sw_addr == ADDR_RST); // R4
            cfg_d.node_addr = (sw_addr == ADDR_RST) ? i_nvm_addr : sw_addr; // R3 R4
            cfg_d.rate_from_nvm = (sw_rate == CODE_NVM); // R5
            cfg_d.rate = (sw_rate == CODE_NVM) ? i_nvm_rate : spc_decode_rate(sw_rate); // R5 R6
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cfg_q <= '0;
            valid_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            valid_q <= valid_d;
        end
    end

    assign o_cfg = cfg_q;
    assign o_cfg_valid = valid_q;

    // ****************************************
    // Encoder buffers
    // ****************************************
    logic [2:0] enc_q;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            enc_q <= '0;
        end else begin
            enc_q <= enc_s; // R7
        end
    end

    // Negative leg is the inverse of the registered level
    assign o_buffered_chan_a_pos = enc_q[2]; // R7
    assign o_buffered_chan_a_neg = !enc_q[2];
    assign o_buffered_chan_b_pos = enc_q[1];
    assign o_buffered_chan_b_neg = !enc_q[1];
    assign o_buffered_index_pos = enc_q[0];
    assign o_buffered_index_neg = !enc_q[0];

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_held;
        o_cfg_valid;
    endsequence

    // Start-up steps after reset release
    sequence s_boot;
        (state_q == SPC_WAIT) ##1 (state_q == SPC_WAIT2) ##1
        (state_q == SPC_SAMPLE) ##1 (state_q == SPC_HOLD);
    endsequence

    a_addr_switch: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R1
        (o_cfg_valid && !o_cfg.addr_from_nvm) |-> o_cfg.node_addr == sw_q[5:0])
        else $error("address not from switches");
    a_addr_nvm: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R4
        (o_cfg_valid && sw_q[5:0] == 6'h00) |-> o_cfg.addr_from_nvm && $past(i_nvm_addr) == o_cfg.node_addr)
        else $error("zero address did not use stored value");
    a_addr_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R4
        o_cfg_valid |-> o_cfg.addr_from_nvm == (sw_addr == ADDR_RST))
        else $error("address source flag wrong");

    a_rate_nvm: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R5
        (o_cfg_valid && sw_q[7:6] == 2'h0) |-> o_cfg.rate_from_nvm && o_cfg.rate == $past(i_nvm_rate))
        else $error("zero rate did not use stored value");
    a_rate_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R5
        o_cfg_valid |-> o_cfg.rate_from_nvm == (sw_rate == CODE_NVM))
        else $error("rate source flag wrong");
    // Stored values follow with one cycle of delay
    a_nvm_follow: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R5
        (o_cfg_valid && o_cfg.rate_from_nvm) |=> o_cfg.rate == $past(i_nvm_rate))
        else $error("stored rate not followed");
    a_rate_decode: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R6
        (o_cfg_valid && sw_q[7:6] == 2'h3) |-> o_cfg.rate == SPC_RATE_115K2 && !o_cfg.rate_from_nvm)
        else $error("rate code three not 115.2");
    a_rate_mid: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R6
        (o_cfg_valid && sw_rate == CODE_38K4) |-> o_cfg.rate == SPC_RATE_38K4 && !o_cfg.rate_from_nvm)
        else $error("rate code two not 38.4");
    a_rate_low: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R6
        (o_cfg_valid && sw_q[7:6] == 2'h1) |-> o_cfg.rate == SPC_RATE_9K6)
        else $error("rate code one not 9.6");

    // ****************************************
    // Latch and select checks
    // ****************************************
    a_switch_held: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R9
        s_held |=> $stable(sw_q) && o_cfg_valid)
        else $error("latched switches changed");
    a_valid_time: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R9
        $rose(i_rst_b) ##0 !o_cfg_valid |-> ##[1:4] o_cfg_valid)
        else $error("configuration not valid in time");
    a_boot_order: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R9
        $rose(i_rst_b) |-> s_boot ##1 o_cfg_valid)
        else $error("start-up steps out of order");
    a_latch_value: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R9
        (state_q == SPC_SAMPLE) |=> sw_q == $past(sw_s))
        else $error("switches not latched in sample step");
    a_hold_state: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R9
        (state_q == SPC_HOLD) |=> (state_q == SPC_HOLD))
        else $error("hold state left before reset");
    a_cfg_idle: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R9
        !o_cfg_valid |-> o_cfg.node_addr == ADDR_RST && o_cfg.rate == SPC_RATE_9K6 &&
        !o_cfg.addr_from_nvm && !o_cfg.rate_from_nvm)
        else $error("configuration fields set before valid");
    a_iface_sel: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R8
        !sel_s |=> o_cfg.is_rs485)
        else $error("low select did not give RS-485");
    a_iface_232: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R8
        sel_s |=> !o_cfg.is_rs485)
        else $error("high select did not give RS-232");

    // ****************************************
    // Encoder checks
    // ****************************************
    a_enc_pair: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R7
        (o_buffered_chan_a_pos != o_buffered_chan_a_neg) &&
        (o_buffered_chan_b_pos != o_buffered_chan_b_neg) &&
        (o_buffered_index_pos != o_buffered_index_neg))
        else $error("encoder pair not complementary");
    a_enc_follow: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R7
        {o_buffered_chan_a_pos, o_buffered_chan_b_pos, o_buffered_index_pos} ==
        $past(enc_s))
        else $error("encoder output not one cycle behind input");
endmodule : spc_top

// ===== dv/spc_wiring.sv
`timescale 1ns/1ps
// ****************
// Select pin wiring on the host link side
// ****************
module spc_wiring (
    // Wiring choice
    input wire logic i_tie_gnd,
    // Level seen at the select pin, pulled up when left open
    output logic o_sel_pin
);
    assign o_sel_pin = i_tie_gnd ? 1'b0 : 1'b1;
endmodule : spc_wiring

// ===== dv/tb.sv
`timescale 1ns/1ps
module tb;
    import spc_pkg::*;
    // ****************
    // Stimulus, outputs and counters
    // ****************
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic [SW_W-1:0] i_switch = 8'h00;
    logic tie_gnd = 1'b1;
    logic i_sel_pin;
    logic [ADDR_W-1:0] i_nvm_addr = 6'h2a;
    spc_rate_t i_nvm_rate = SPC_RATE_38K4;
    spc_enc_t i_enc = 3'h0;
    spc_cfg_t o_cfg;
    logic o_cfg_valid;
    logic [5:0] enc_out;
    int fails = 0;
    int cmp_count = 0;
    logic [7:0] sw_tab [6] = '{8'h00, 8'h01, 8'h7f, 8'hbf, 8'hc0, 8'h55};
    logic [10:0] cfg_tab [6] = '{11'h6a7, 11'h415, 11'h7f0, 11'h7f4, 11'h6aa, 11'h550};
    always #2 i_core_clk = ~i_core_clk;
    spc_wiring i_wire (.i_tie_gnd(tie_gnd), .o_sel_pin(i_sel_pin));
    spc_top i_dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_switch(i_switch),
        .i_sel_pin(i_sel_pin), .i_nvm_addr(i_nvm_addr), .i_nvm_rate(i_nvm_rate),
        .i_enc(i_enc), .o_cfg(o_cfg), .o_cfg_valid(o_cfg_valid),
        .o_buffered_chan_a_pos(enc_out[5]), .o_buffered_chan_a_neg(enc_out[4]),
        .o_buffered_chan_b_pos(enc_out[3]), .o_buffered_chan_b_neg(enc_out[2]),
        .o_buffered_index_pos(enc_out[1]), .o_buffered_index_neg(enc_out[0]));
    // ****************
    // Shared tasks
    // ****************
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : wait_cycles
    // Reset with switches set, then wait for the configuration
    task automatic boot(input logic [7:0] sw);
        int n;
        @(posedge i_core_clk);
        i_rst_b <= 1'b0;
        i_switch <= sw;
        wait_cycles(2);
        check(16'({o_cfg_valid, o_cfg}), 16'h0000);
        check(16'(enc_out), 16'h0015);
        @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        n = 0;
        while (o_cfg_valid !== 1'b1 && n < 10) begin
            wait_cycles(1);
            n++;
        end
        if (o_cfg_valid !== 1'b1) begin
            fails++;
            tally_and_finish();
        end
    endtask : boot
    // ****************
    // Sequence
    // ****************
    initial begin
        wait_cycles(2);
        for (int r = 0; r < 6; r++) begin
            boot(sw_tab[r]);
            check(16'(o_cfg), 16'(cfg_tab[r]));
        end
        @(posedge i_core_clk);
        i_switch <= 8'haa;
        wait_cycles(6);
        check(16'(o_cfg), 16'h0550);
        @(posedge i_core_clk);
        tie_gnd <= 1'b0;
        wait_cycles(6);
        check(16'(o_cfg), 16'h0150);
        @(posedge i_core_clk);
        tie_gnd <= 1'b1;
        wait_cycles(6);
        check(16'(o_cfg), 16'h0550);
        boot(8'h00);
        check(16'(o_cfg), 16'h06a7);
        @(posedge i_core_clk);
        i_nvm_addr <= 6'h11;
        i_nvm_rate <= SPC_RATE_115K2;
        wait_cycles(4);
        check(16'(o_cfg), 16'h051b);
        for (int e = 0; e < 8; e++) begin
            @(posedge i_core_clk);
            i_enc <= e[2:0];
            wait_cycles(5);
            check(16'(enc_out), 16'({e[2], ~e[2], e[1], ~e[1], e[0], ~e[0]}));
        end
        tally_and_finish();
    end
endmodule : tb
